// ===== design/pcov_pkg.sv
// Package of constants for the performance counter overflow block
package pcov_pkg;
  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] PERF_COUNTER_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] FIRST_COUNTER_ADDR        = 8'h04;
  localparam logic [7:0] SECOND_COUNTER_ADDR       = 8'h08;
  localparam logic [7:0] FETCH_CONTROL_ADDR        = 8'h0c;
  localparam logic [7:0] PROCESS_CONTEXT_ADDR      = 8'h10;
  localparam logic [7:0] INTERRUPT_STATUS_ADDR     = 8'h14;
  localparam logic [7:0] INTERRUPT_MASK_ADDR       = 8'h18;
  localparam logic [7:0] INTERRUPT_REQUEST_CLEAR_ADDR = 8'h1c;

  // ---------------------------------------------------------------------
  // Counter geometry
  // ---------------------------------------------------------------------
  localparam int unsigned CNT_W = 20;
  localparam logic [CNT_W-1:0] FIRST_STEP  = 20'h00010;
  localparam logic [CNT_W-1:0] SECOND_STEP = 20'h00004;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 20'h00000;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int unsigned FIRST_BIT  = 0;
  localparam int unsigned SECOND_BIT = 1;
  localparam logic [1:0]  EN_RESET   = 2'h0;
  localparam logic [31:0] ZERO_WORD  = 32'h00000000;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pcov_pkg

// ===== design/pcov_counter.sv
// One performance counter with write load and overflow latch
`timescale 1ns/1ns
module pcov_counter #(
  parameter logic [pcov_pkg::CNT_W-1:0] STEP = pcov_pkg::FIRST_STEP
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      enable,
  input  wire logic                      event_in,
  input  wire logic                      load,
  input  wire logic [pcov_pkg::CNT_W-1:0] load_value,
  output logic      [pcov_pkg::CNT_W-1:0] value,
  output logic                           overflow_pulse
);
  typedef struct packed {
    logic [pcov_pkg::CNT_W-1:0] count;
    logic                       ovf;
  } pcov_cnt_state_type;

  pcov_cnt_state_type state_q;
  pcov_cnt_state_type state_d;

  function automatic logic carry_out(input logic [pcov_pkg::CNT_W-1:0] v,
                                     input logic inc);
    logic [pcov_pkg::CNT_W:0] s;
    s = {1'b0, v} + {1'b0, (inc ? STEP : pcov_pkg::CNT_ZERO)};
    return s[pcov_pkg::CNT_W];
  endfunction : carry_out

  always_comb
  begin
    state_d = state_q;
    if (load)
    begin
      // Flag follows the newly loaded value plus present inputs
      state_d.count = load_value;
      state_d.ovf   = carry_out(load_value, event_in);
    end
    else if (enable)
    begin
      if (state_q.ovf)
      begin
        state_d.count = pcov_pkg::CNT_ZERO;
        state_d.ovf   = 1'b0;
      end
      else if (event_in)
      begin
        state_d.count = state_q.count + STEP;
        // Carry of this very step, so the pulse rises in the same cycle as the wrap
        state_d.ovf   = carry_out(state_q.count, 1'b1);
      end
    end
    // Disabled: count and flag frozen, stale flag keeps firing
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q.count <= pcov_pkg::CNT_ZERO;
      state_q.ovf   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign value          = state_q.count;
  assign overflow_pulse = state_q.ovf;
endmodule : pcov_counter

// ===== design/pcov_top.sv
// Performance counter overflow block with AXI4-Lite registers
`timescale 1ns/1ns
module pcov_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  count_event,
  input  wire logic        other_irq_req,
  output logic             other_irq_grant,
  output logic             perf_irq
);
  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  ctl_select;
    logic [1:0]  fetch_en;
    logic [1:0]  ctx_en;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        req;
  } pcov_state_type;

  pcov_state_type s_q;
  pcov_state_type s_d;

  logic [pcov_pkg::CNT_W-1:0] cnt_val [2];
  logic [1:0]                 ovf;
  logic [1:0]                 cnt_en;
  logic [1:0]                 cnt_load;
  logic                       wr_go;
  logic                       rd_go;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // -----------------------------------------------------------------------
  // Counters
  // -----------------------------------------------------------------------
  assign cnt_en = s_q.fetch_en & s_q.ctx_en;
  assign wr_go  = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign rd_go  = s_axi_arvalid && !s_q.rvalid;

  always_comb
  begin
    cnt_load = 2'h0;
    if (wr_go && s_q.aw_addr == pcov_pkg::FIRST_COUNTER_ADDR)
    begin
      cnt_load[pcov_pkg::FIRST_BIT] = 1'b1;
    end
    else if (wr_go && s_q.aw_addr == pcov_pkg::SECOND_COUNTER_ADDR)
    begin
      cnt_load[pcov_pkg::SECOND_BIT] = 1'b1;
    end
  end

  // Loading near overflow is software's duty; hardware does not guard it
  pcov_counter #(
    .STEP (pcov_pkg::FIRST_STEP)
  ) u_first (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .enable         (cnt_en[pcov_pkg::FIRST_BIT]),
    .event_in       (count_event[pcov_pkg::FIRST_BIT]),
    .load           (cnt_load[pcov_pkg::FIRST_BIT]),
    .load_value     (s_q.w_data[pcov_pkg::CNT_W-1:0]),
    .value          (cnt_val[0]),
    .overflow_pulse (ovf[pcov_pkg::FIRST_BIT])
  );

  pcov_counter #(
    .STEP (pcov_pkg::SECOND_STEP)
  ) u_second (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .enable         (cnt_en[pcov_pkg::SECOND_BIT]),
    .event_in       (count_event[pcov_pkg::SECOND_BIT]),
    .load           (cnt_load[pcov_pkg::SECOND_BIT]),
    .load_value     (s_q.w_data[pcov_pkg::CNT_W-1:0]),
    .value          (cnt_val[1]),
    .overflow_pulse (ovf[pcov_pkg::SECOND_BIT])
  );

  // -----------------------------------------------------------------------
  // Interrupt arbitration
  // -----------------------------------------------------------------------
  // Overflow has priority; an enabled one lasts one cycle, a stale one lasts
  assign other_irq_grant = other_irq_req && (ovf == 2'h0);
  assign perf_irq        = s_q.req || ((s_q.status & s_q.mask) != 2'h0);

  // -----------------------------------------------------------------------
  // Register file and bus
  // -----------------------------------------------------------------------
  always_comb
  begin
    logic [31:0] wv;
    logic [7:0]  ra;
    logic [1:0]  clr;
    wv  = merge(pcov_pkg::ZERO_WORD, s_q.w_data, s_q.w_strb);
    ra  = s_axi_araddr;
    clr = 2'h0;
    s_d = s_q;

    if (s_axi_awvalid && !s_q.aw_have)
    begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_have)
    begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end

    if (wr_go)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = pcov_pkg::RESP_OKAY;
      if (s_q.aw_addr == pcov_pkg::PERF_COUNTER_CONTROL_ADDR)
      begin
        s_d.ctl_select = wv[1:0];
      end
      else if (s_q.aw_addr == pcov_pkg::FIRST_COUNTER_ADDR ||
               s_q.aw_addr == pcov_pkg::SECOND_COUNTER_ADDR)
      begin
        s_d.bresp = pcov_pkg::RESP_OKAY;
      end
      else if (s_q.aw_addr == pcov_pkg::FETCH_CONTROL_ADDR)
      begin
        s_d.fetch_en = wv[1:0];
      end
      else if (s_q.aw_addr == pcov_pkg::PROCESS_CONTEXT_ADDR)
      begin
        s_d.ctx_en = wv[1:0];
      end
      else if (s_q.aw_addr == pcov_pkg::INTERRUPT_MASK_ADDR)
      begin
        s_d.mask = wv[1:0];
      end
      else if (s_q.aw_addr == pcov_pkg::INTERRUPT_REQUEST_CLEAR_ADDR)
      begin
        clr = wv[1:0];
      end
      else if (s_q.aw_addr != pcov_pkg::INTERRUPT_STATUS_ADDR)
      begin
        s_d.bresp = pcov_pkg::RESP_SLVERR;
      end
    end

    if (rd_go)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = pcov_pkg::RESP_OKAY;
      s_d.rdata  = pcov_pkg::ZERO_WORD;
      if (ra == pcov_pkg::PERF_COUNTER_CONTROL_ADDR)
      begin
        s_d.rdata[1:0] = s_q.ctl_select;
      end
      else if (ra == pcov_pkg::FIRST_COUNTER_ADDR)
      begin
        s_d.rdata[pcov_pkg::CNT_W-1:0] = cnt_val[0];
      end
      else if (ra == pcov_pkg::SECOND_COUNTER_ADDR)
      begin
        s_d.rdata[pcov_pkg::CNT_W-1:0] = cnt_val[1];
      end
      else if (ra == pcov_pkg::FETCH_CONTROL_ADDR)
      begin
        s_d.rdata[1:0] = s_q.fetch_en;
      end
      else if (ra == pcov_pkg::PROCESS_CONTEXT_ADDR)
      begin
        s_d.rdata[1:0] = s_q.ctx_en;
      end
      else if (ra == pcov_pkg::INTERRUPT_STATUS_ADDR)
      begin
        s_d.rdata[1:0] = s_q.status;
        s_d.rdata[2]   = s_q.req;
      end
      else if (ra == pcov_pkg::INTERRUPT_MASK_ADDR)
      begin
        s_d.rdata[1:0] = s_q.mask;
      end
      else if (ra != pcov_pkg::INTERRUPT_REQUEST_CLEAR_ADDR)
      begin
        s_d.rresp = pcov_pkg::RESP_SLVERR;
      end
    end

    // Status clears on read; a new overflow in that cycle still sets
    if (rd_go && ra == pcov_pkg::INTERRUPT_STATUS_ADDR)
    begin
      s_d.status = 2'h0;
    end
    s_d.status = s_d.status | ovf;
    // Pending request: clear by write-one, overflow set wins
    if (clr != 2'h0)
    begin
      s_d.req = 1'b0;
    end
    if (ovf != 2'h0)
    begin
      s_d.req = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q.aw_have    <= 1'b0;
      s_q.aw_addr    <= 8'h00;
      s_q.w_have     <= 1'b0;
      s_q.w_data     <= pcov_pkg::ZERO_WORD;
      s_q.w_strb     <= 4'h0;
      s_q.bvalid     <= 1'b0;
      s_q.bresp      <= pcov_pkg::RESP_OKAY;
      s_q.rvalid     <= 1'b0;
      s_q.rdata      <= pcov_pkg::ZERO_WORD;
      s_q.rresp      <= pcov_pkg::RESP_OKAY;
      s_q.ctl_select <= pcov_pkg::EN_RESET;
      s_q.fetch_en   <= pcov_pkg::EN_RESET;
      s_q.ctx_en     <= pcov_pkg::EN_RESET;
      s_q.status     <= 2'h0;
      s_q.mask       <= 2'h0;
      s_q.req        <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.aw_have;
  assign s_axi_wready  = !s_q.w_have;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
endmodule : pcov_top

// ===== dv/pcov_top_asserts.sv
// Concurrent checks on the ports of the performance counter block
`timescale 1ns/1ns
module pcov_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic other_irq_req,
  input wire logic other_irq_grant,
  input wire logic perf_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_grant_req: assert property (
    other_irq_grant |-> other_irq_req) else $error("grant without request");
  chk_block_irq: assert property (
    other_irq_req && !other_irq_grant |=> perf_irq) else $error("overflow without irq");
  // Bus activity may legally clear the request, so quiet cycles only
  chk_irq_pending: assert property (
    perf_irq && !s_axi_awvalid && !$past(s_axi_awvalid) && !s_axi_arvalid
    && !$past(s_axi_arvalid) |=> perf_irq) else $error("irq dropped");
  chk_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  chk_ar_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  chk_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready ##1 1'b1
    |-> ##[0:2] s_axi_bvalid) else $error("no write response");
  chk_b_single: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response repeated");
  chk_reset_idle: assert property (
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !perf_irq) else $error("not idle");
endmodule : pcov_top_chk

bind pcov_top pcov_top_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .other_irq_req, .other_irq_grant, .perf_irq);

// ===== dv/tb.sv
// Self-checking testbench for the performance counter block
`timescale 1ns/1ns
module tb;
  typedef struct {string n; logic [33:0] v; logic [33:0] m;} pcov_note_type;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic [7:0]    s_axi_awaddr = 8'h00;
  logic          s_axi_awvalid = 1'b0;
  logic          s_axi_awready;
  logic [31:0]   s_axi_wdata = 32'h0;
  logic [3:0]    s_axi_wstrb = 4'hf;
  logic          s_axi_wvalid = 1'b0;
  logic          s_axi_wready;
  logic [1:0]    s_axi_bresp;
  logic          s_axi_bvalid;
  logic          s_axi_bready = 1'b0;
  logic [7:0]    s_axi_araddr = 8'h00;
  logic          s_axi_arvalid = 1'b0;
  logic          s_axi_arready;
  logic [31:0]   s_axi_rdata;
  logic [1:0]    s_axi_rresp;
  logic          s_axi_rvalid;
  logic          s_axi_rready = 1'b0;
  logic [1:0]    count_event = 2'h0;
  logic          other_irq_req = 1'b0;
  logic          other_irq_grant;
  logic          perf_irq;
  int            err_count = 0;
  int            compares = 0;
  int            blk = 0;
  int            n;
  pcov_note_type rq[$];
  pcov_note_type bq[$];
  pcov_note_type e;

  always #25 aclk = ~aclk;

  pcov_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_event,
    .other_irq_req, .other_irq_grant, .perf_irq);

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------------
  // Bus master
  // ---------------------------------------------------------------------
  // Handshakes are judged at the falling edge, before the edge that moves them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int  i;
    logic aw_t;
    logic w_t;
    bq.push_back('{"bresp", {32'h0, r}, 34'h3});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && bq.size() == 0)
      begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    // An edge between calls, so a ready is never reassigned in one step
    @(posedge aclk);
    if (i == 50)
    begin
      err_count++;
      $display("CHECK FAILED write exp done seen hang");
      final_report();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] v, input logic [33:0] m,
                    input string nm);
    int   i;
    logic ar_t;
    rq.push_back('{nm, v, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (rq.size() == 0)
      begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
    if (i == 50)
    begin
      err_count++;
      $display("CHECK FAILED read exp done seen hang");
      final_report();
    end
  endtask : rd

  // Watcher: oldest note against each answer, and cycles other irqs wait
  always @(negedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
    begin
      e = rq.pop_front();
      check(e.n, {s_axi_rresp, s_axi_rdata} & e.m, e.v & e.m);
    end
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
    begin
      e = bq.pop_front();
      check(e.n, {32'h0, s_axi_bresp}, e.v);
    end
    if (other_irq_req && !other_irq_grant) blk++;
  end

  task automatic irq_seq();
    rd(8'h14, 34'h5, '1, "status_set");
    rd(8'h14, 34'h4, '1, "status_pend");
    wr(8'h1c, 32'h1, pcov_pkg::RESP_OKAY);
    rd(8'h14, 34'h0, '1, "status_clr");
    @(negedge aclk) check("perf_irq", {33'h0, perf_irq}, 34'h0);
    @(posedge aclk);
  endtask : irq_seq

  initial
  begin
    void'($urandom(32'h5d89260e));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (n = 0; n < 8; n++) rd(8'(n * 4), 34'h0, '1, "reset_val");
    rd(8'h20, {pcov_pkg::RESP_SLVERR, 32'h0}, 34'h300000000, "unmapped");
    wr(8'h20, 32'h1, pcov_pkg::RESP_SLVERR);
    wr(8'h14, 32'hf, pcov_pkg::RESP_OKAY);
    wr(8'h00, 32'h3, pcov_pkg::RESP_OKAY);
    rd(8'h00, 34'h3, '1, "control");
    $display("test registers done");
    other_irq_req <= 1'b1;
    wr(8'h0c, 32'h1, pcov_pkg::RESP_OKAY);
    count_event <= 2'h3;
    repeat (4) @(posedge aclk);
    count_event <= 2'h0;
    rd(8'h04, 34'h0, '1, "first_off");
    wr(8'h10, 32'h3, pcov_pkg::RESP_OKAY);
    wr(8'h0c, 32'h3, pcov_pkg::RESP_OKAY);
    n = 1 + $urandom % 8;
    count_event <= 2'h3;
    repeat (n) @(posedge aclk);
    count_event <= 2'h0;
    rd(8'h04, 34'(n * 16), '1, "first_cnt");
    rd(8'h08, 34'(n * 4), '1, "second_cnt");
    $display("test enables done");
    wr(8'h18, 32'h3, pcov_pkg::RESP_OKAY);
    rd(8'h18, 34'h3, '1, "mask");
    wr(8'h04, 32'hfffe0, pcov_pkg::RESP_OKAY);
    blk = 0;
    count_event <= 2'h1;
    repeat (2) @(posedge aclk);
    check("early_ovf", 34'(blk), 34'h0);
    count_event <= 2'h0;
    repeat (3) @(posedge aclk);
    check("blocked", 34'(blk), 34'h1);
    rd(8'h04, 34'h0, '1, "wrapped");
    irq_seq();
    $display("test overflow done");
    wr(8'h10, 32'h2, pcov_pkg::RESP_OKAY);
    // Deliberately parked at wrap with an event in the load cycle
    count_event <= 2'h1;
    wr(8'h04, 32'hffff0, pcov_pkg::RESP_OKAY);
    count_event <= 2'h0;
    blk = 0;
    repeat (10) @(posedge aclk);
    check("stale", 34'(blk), 34'd10);
    wr(8'h04, 32'h0, pcov_pkg::RESP_OKAY);
    wr(8'h04, 32'h0, pcov_pkg::RESP_OKAY);
    blk = 0;
    repeat (5) @(posedge aclk);
    check("unstale", 34'(blk), 34'h0);
    irq_seq();
    $display("test stale overflow done");
    final_report();
  end
endmodule : tb
